// ==== rtl/smc_pkg.sv ====
package smc_pkg;
  // clock and timer tick
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_PAYLOAD = 100;
  localparam int LINE_MAX = 8;
  localparam int REP_MAX = 6;
  // settings: index and reset value (timeouts in timer ticks)
  localparam int NPAR = 6;
  localparam int P_PKT_TO = 0;
  localparam int P_GUARD = 1;
  localparam int P_ESC = 2;
  localparam int P_CMD_TO = 3;
  localparam int P_BAUD = 4;
  localparam int P_DEST = 5;
  localparam logic [15:0] PAR_DEF [NPAR] = '{16'h0003, 16'h03E8, 16'h002B,
                                            16'h2710, 16'h0003, 16'h0000};
  // characters
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_K = 8'h4B;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_CR = 8'h0D;
  // two-character command codes
  localparam logic [15:0] CMD_PKT_TO = 16'h524F;
  localparam logic [15:0] CMD_GUARD = 16'h4754;
  localparam logic [15:0] CMD_ESC = 16'h4343;
  localparam logic [15:0] CMD_CMD_TO = 16'h4354;
  localparam logic [15:0] CMD_BAUD = 16'h4244;
  localparam logic [15:0] CMD_DEST = 16'h444C;
  localparam logic [15:0] CMD_APPLY = 16'h4143;
  localparam logic [15:0] CMD_EXIT = 16'h434E;
  localparam logic [15:0] CMD_STORE = 16'h5752;
  // register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PAR0 = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h1C;
  localparam int CTRL_APPLY_BIT = 0;
  localparam int CTRL_STORE_BIT = 1;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_TRX_LSB = 12;
  localparam int ST_ESC_LSB = 16;
  // modes
  typedef enum logic [1:0] {MODE_DATA, MODE_FLUSH, MODE_CMD} smc_mode_t;
  typedef enum logic [1:0] {TRX_IDLE, TRX_RX, TRX_TX} smc_trx_t;
endpackage : smc_pkg

// ==== rtl/smc_ctrl.sv ====
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic uart_sel,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  output logic cts_n,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  input wire logic rf_busy,
  input wire logic rf_rx_valid,
  input wire logic [7:0] rf_rx_data,
  output logic rf_rx_ready,
  output logic rf_tx_valid,
  output logic [7:0] rf_tx_data,
  output logic rf_tx_last,
  input wire logic rf_tx_ready,
  output logic [15:0] rf_dest,
  output logic [2:0] baud_sel,
  output logic [1:0] trx_state,
  output logic [1:0] op_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int PW = $clog2(TICK_CYC + 1);

  logic sel_m_q, sel_q;
  logic [PW-1:0] pre_q;
  logic [15:0] idle_q;
  smc_mode_t mode_q;
  smc_trx_t trx_q;
  logic [7:0] buf_q [MAX_PAYLOAD];
  logic [6:0] cnt_q, sidx_q, esc_base_q;
  logic [1:0] esc_q;
  logic send_q, cts_n_q;
  logic tx_valid_q, tx_last_q;
  logic [7:0] tx_data_q;
  logic [15:0] act_q [NPAR];
  logic [15:0] pend_q [NPAR];
  logic [15:0] nv_q [NPAR];
  logic loaded_q;
  logic [7:0] line_q [LINE_MAX];
  logic [3:0] llen_q;
  logic lovf_q;
  logic [7:0] rep_q [REP_MAX];
  logic [2:0] rlen_q, ridx_q;
  logic stx_valid_q, rrdy_q;
  logic [7:0] stx_data_q;
  logic [31:0] rdata_q;
  logic [15:0] arg_val;
  logic arg_bad;
  logic [2:0] pidx;
  logic pok;

  // pin level crossing; first stage feeds only the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_m_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sel_m_q <= uart_sel;
      sel_q <= sel_m_q;
    end
  end

  // timer tick prescaler
  wire tick = (pre_q == PW'(TICK_CYC - 1));
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
    end
  end

  // serial input is ignored unless the uart is the serial interface
  wire rx_fire = ser_rx_valid && sel_q;
  wire cmd_in = rx_fire && (mode_q == MODE_CMD);
  wire cr_fire = cmd_in && (ser_rx_data == CH_CR);

  // trigger and escape decode
  wire guard_ok = idle_q >= act_q[P_GUARD];
  wire is_esc = ser_rx_data == act_q[P_ESC][7:0];
  wire size_hit = cnt_q == 7'(MAX_PAYLOAD);
  wire ro_hit = (esc_q == 2'd0) && (idle_q >= act_q[P_PKT_TO]);
  // a fresh character defers a trigger: size and flush ones by one cycle, the idle one until a new silence
  wire start_tx = !send_q && (cnt_q != 7'd0) && !rf_busy && !rx_fire &&
                  ((mode_q == MODE_FLUSH) || size_hit ||
                   ((mode_q == MODE_DATA) && ro_hit));
  wire data_in = rx_fire && (mode_q == MODE_DATA) && !send_q &&
                 (cnt_q < 7'(MAX_PAYLOAD));
  wire esc_step = data_in && is_esc &&
                  ((esc_q == 2'd0) ? guard_ok : (esc_q != 2'd3));
  wire enter_cmd = (mode_q == MODE_DATA) && (esc_q == 2'd3) && guard_ok &&
                   !rx_fire && sel_q;
  wire flush_done = (mode_q == MODE_FLUSH) && (cnt_q == 7'd0) && !send_q;
  wire tx_take = tx_valid_q && rf_tx_ready;
  wire cmd_to = (mode_q == MODE_CMD) && !rx_fire &&
                (idle_q >= act_q[P_CMD_TO]);

  // silence counter, restarted per character and on command entry
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_q <= 16'h0000;
    end else if (rx_fire || flush_done) begin
      idle_q <= 16'h0000;
    end else if (tick && (idle_q != 16'hFFFF)) begin
      idle_q <= idle_q + 16'h0001;
    end
  end

  // command line parse
  wire [15:0] code = {line_q[2], line_q[3]};
  wire at_ok = !lovf_q && (llen_q >= 4'd4) && (line_q[0] == CH_A) &&
               (line_q[1] == CH_T);
  wire has_arg = llen_q > 4'd4;
  wire is_apply = code == CMD_APPLY;
  wire is_exit = code == CMD_EXIT;
  wire is_store = code == CMD_STORE;
  wire do_read = at_ok && pok && !has_arg;
  wire do_write = at_ok && pok && has_arg && !arg_bad;
  wire do_act = at_ok && !has_arg && (is_apply || is_exit || is_store);
  wire cmd_good = do_read || do_write || do_act;
  wire cmd_exit = (cr_fire && do_act && is_exit) || cmd_to;
  wire reg_par = (reg_addr >= REG_PAR0) && (reg_addr < REG_CTRL) &&
                 (reg_addr[1:0] == 2'b00);
  wire [2:0] reg_pidx = 3'((reg_addr - REG_PAR0) >> 2);
  wire reg_ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
  wire apply = (cr_fire && do_act && is_apply) || cmd_exit ||
               (reg_ctrl_wr && reg_wdata[CTRL_APPLY_BIT]);
  wire store = (cr_fire && do_act && is_store) ||
               (reg_ctrl_wr && reg_wdata[CTRL_STORE_BIT]);

  // hex value of the argument field
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    arg_val = 16'h0000;
    arg_bad = 1'b0;
    for (int i = 4; i < LINE_MAX; i++) begin
      if (4'(i) < llen_q) begin
        c = line_q[i] | 8'h20;
        if (c >= 8'h30 && c <= 8'h39) begin
          arg_val = {arg_val[11:0], c[3:0]};
        end else if (c >= 8'h61 && c <= 8'h66) begin
          arg_val = {arg_val[11:0], c[3:0] + 4'd9};
        end else begin
          arg_bad = 1'b1;
        end
      end
    end
  end

  // setting selected by the command name
  always_comb begin
    pok = 1'b1;
    case (code)
      CMD_PKT_TO: pidx = 3'(P_PKT_TO);
      CMD_GUARD: pidx = 3'(P_GUARD);
      CMD_ESC: pidx = 3'(P_ESC);
      CMD_CMD_TO: pidx = 3'(P_CMD_TO);
      CMD_BAUD: pidx = 3'(P_BAUD);
      CMD_DEST: pidx = 3'(P_DEST);
      default: begin
        pidx = 3'd0;
        pok = 1'b0;
      end
    endcase
  end

  // input buffer storage, no reset needed for a memory
  always_ff @(posedge core_clk) begin
    if (data_in) begin
      buf_q[cnt_q] <= ser_rx_data;
    end
  end

  // buffer count, escape tracking, packet send and mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= MODE_DATA;
      cnt_q <= 7'd0;
      sidx_q <= 7'd0;
      esc_q <= 2'd0;
      esc_base_q <= 7'd0;
      send_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
    end else begin
      if (data_in) begin
        cnt_q <= cnt_q + 7'd1;
      end
      if (start_tx) begin
        esc_q <= 2'd0;
      end else if (esc_step) begin
        if (esc_q == 2'd0) begin
          esc_base_q <= cnt_q;
        end
        esc_q <= esc_q + 2'd1;
      end else if (data_in) begin
        esc_q <= 2'd0;
      end
      if (enter_cmd) begin
        mode_q <= MODE_FLUSH;
        cnt_q <= esc_base_q;
        esc_q <= 2'd0;
      end
      if (start_tx) begin
        send_q <= 1'b1;
        sidx_q <= 7'd0;
        tx_valid_q <= 1'b1;
        tx_data_q <= buf_q[0];
        tx_last_q <= cnt_q == 7'd1;
      end else if (tx_take) begin
        if (tx_last_q) begin
          send_q <= 1'b0;
          tx_valid_q <= 1'b0;
          tx_last_q <= 1'b0;
          cnt_q <= 7'd0;
        end else begin
          sidx_q <= sidx_q + 7'd1;
          tx_data_q <= buf_q[sidx_q + 7'd1];
          tx_last_q <= (sidx_q + 7'd2) == cnt_q;
        end
      end
      if (flush_done) begin
        mode_q <= MODE_CMD;
      end else if (cmd_exit) begin
        mode_q <= MODE_DATA;
      end
    end
  end

  // command line collection
  always_ff @(posedge core_clk) begin
    if (cmd_in && !cr_fire && (llen_q < 4'(LINE_MAX))) begin
      line_q[llen_q[2:0]] <= ser_rx_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      llen_q <= 4'd0;
      lovf_q <= 1'b0;
    end else if (cr_fire || mode_q != MODE_CMD) begin
      llen_q <= 4'd0;
      lovf_q <= 1'b0;
    end else if (cmd_in) begin
      if (llen_q == 4'(LINE_MAX)) begin
        lovf_q <= 1'b1;
      end else begin
        llen_q <= llen_q + 4'd1;
      end
    end
  end

  // active and pending settings, reloaded from storage after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 1'b0;
      for (int i = 0; i < NPAR; i++) begin
        act_q[i] <= PAR_DEF[i];
        pend_q[i] <= PAR_DEF[i];
      end
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      for (int i = 0; i < NPAR; i++) begin
        act_q[i] <= nv_q[i];
        pend_q[i] <= nv_q[i];
      end
    end else begin
      if (reg_wr && reg_par) begin
        pend_q[reg_pidx] <= reg_wdata[15:0];
      end
      if (cr_fire && do_write) begin
        pend_q[pidx] <= arg_val;
      end
      if (apply) begin
        for (int i = 0; i < NPAR; i++) begin
          act_q[i] <= pend_q[i];
        end
      end
    end
  end

  // storage keeps its contents across reset_n; only power-on reloads the defaults
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < NPAR; i++) begin
        nv_q[i] <= PAR_DEF[i];
      end
    end else if (store && loaded_q) begin
      for (int i = 0; i < NPAR; i++) begin
        nv_q[i] <= pend_q[i];
      end
    end
  end

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'd10) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_ch

  // replies and serial output; a radio byte already granted wins
  wire rep_pend = ridx_q != rlen_q;
  wire rf_take = rf_rx_valid && rrdy_q;
  wire [15:0] rd_val = pend_q[pidx];
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rlen_q <= 3'd0;
      ridx_q <= 3'd0;
      stx_valid_q <= 1'b0;
      stx_data_q <= 8'h00;
      rrdy_q <= 1'b0;
      for (int i = 0; i < REP_MAX; i++) begin
        rep_q[i] <= 8'h00;
      end
    end else begin
      rrdy_q <= (mode_q == MODE_DATA) && !rep_pend && !stx_valid_q &&
                !rf_take;
      if (stx_valid_q && ser_tx_ready) begin
        stx_valid_q <= 1'b0;
      end else if (rf_take) begin
        stx_valid_q <= 1'b1;
        stx_data_q <= rf_rx_data;
      end else if (!stx_valid_q && rep_pend) begin
        stx_valid_q <= 1'b1;
        stx_data_q <= rep_q[ridx_q];
        ridx_q <= ridx_q + 3'd1;
      end
      if (flush_done) begin
        rep_q[0] <= CH_O;
        rep_q[1] <= CH_K;
        rep_q[2] <= CH_CR;
        rlen_q <= 3'd3;
        ridx_q <= 3'd0;
      end else if (cr_fire) begin
        ridx_q <= 3'd0;
        if (do_read) begin
          rep_q[0] <= hex_ch(rd_val[15:12]);
          rep_q[1] <= hex_ch(rd_val[11:8]);
          rep_q[2] <= hex_ch(rd_val[7:4]);
          rep_q[3] <= hex_ch(rd_val[3:0]);
          rep_q[4] <= CH_CR;
          rlen_q <= 3'd5;
        end else if (cmd_good) begin
          rep_q[0] <= CH_O;
          rep_q[1] <= CH_K;
          rep_q[2] <= CH_CR;
          rlen_q <= 3'd3;
        end else begin
          rep_q[0] <= CH_E;
          rep_q[1] <= CH_R;
          rep_q[2] <= CH_R;
          rep_q[3] <= CH_O;
          rep_q[4] <= CH_R;
          rep_q[5] <= CH_CR;
          rlen_q <= 3'd6;
        end
      end
    end
  end

  // flow control, transceiver state and register reads
  wire [31:0] status_w = 32'(cnt_q) | (32'(mode_q) << ST_MODE_LSB) |
                         (32'(trx_q) << ST_TRX_LSB) |
                         (32'(esc_q) << ST_ESC_LSB);
  wire [31:0] rd_mux = (reg_addr == REG_STATUS) ? status_w :
                       reg_par ? {16'h0000, act_q[reg_pidx]} : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_n_q <= 1'b1;
      trx_q <= TRX_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      // two places of margin cover the registered stop
      cts_n_q <= !sel_q || send_q || start_tx || (mode_q == MODE_FLUSH) ||
                 (cnt_q >= 7'(MAX_PAYLOAD - 2));
      trx_q <= send_q ? TRX_TX : (rf_busy ? TRX_RX : TRX_IDLE);
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign cts_n = cts_n_q;
  assign ser_tx_valid = stx_valid_q;
  assign ser_tx_data = stx_data_q;
  assign rf_rx_ready = rrdy_q;
  assign rf_tx_valid = tx_valid_q;
  assign rf_tx_data = tx_data_q;
  assign rf_tx_last = tx_last_q;
  assign rf_dest = act_q[P_DEST];
  assign baud_sel = act_q[P_BAUD][2:0];
  assign trx_state = trx_q;
  assign op_mode = mode_q;
  assign reg_rdata = rdata_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire [15:0] pend_baud = pend_q[P_BAUD];

  sequence s_flush;
    mode_q == MODE_FLUSH ##1 mode_q == MODE_FLUSH;
  endsequence
  property p_size;
    size_hit && !send_q && !rf_busy && !rx_fire |=> send_q && tx_valid_q;
  endproperty
  a_size: assert property (p_size) else $error("full buffer not sent");
  property p_busy;
    rf_busy && !send_q |=> !tx_valid_q;
  endproperty
  a_busy: assert property (p_busy) else $error("sent while busy");
  property p_ro;
    mode_q == MODE_DATA && ro_hit && cnt_q != 7'd0 && !send_q && !rf_busy &&
    !rx_fire |=> tx_valid_q;
  endproperty
  a_ro: assert property (p_ro) else $error("idle timeout missed");
  property p_enter;
    enter_cmd |=> mode_q == MODE_FLUSH && cnt_q == $past(esc_base_q);
  endproperty
  a_enter: assert property (p_enter) else $error("bad escape entry");
  property p_ok;
    flush_done |=> mode_q == MODE_CMD && rlen_q == 3'd3 && rep_q[1] == CH_K;
  endproperty
  a_ok: assert property (p_ok) else $error("no OK on entry");
  property p_hold_ok;
    s_flush |-> !rep_pend || rlen_q != 3'd3 || ridx_q != 3'd0;
  endproperty
  a_hold_ok: assert property (p_hold_ok) else $error("OK too early");
  property p_to;
    cmd_to |=> mode_q == MODE_DATA ##1 mode_q == MODE_DATA;
  endproperty
  a_to: assert property (p_to) else $error("timeout ignored");
  property p_apply;
    cmd_exit && loaded_q |=> act_q[P_BAUD] == $past(pend_baud);
  endproperty
  a_apply: assert property (p_apply) else $error("exit not applied");
  property p_err;
    cr_fire && !cmd_good |=> rlen_q == 3'd6 ##1 stx_valid_q || rf_take;
  endproperty
  a_err: assert property (p_err) else $error("no ERROR reply");
  property p_abort;
    esc_q != 2'd0 && data_in && !is_esc && !start_tx |=> esc_q == 2'd0;
  endproperty
  a_abort: assert property (p_abort) else $error("escape not aborted");
  property p_spi;
    !sel_q [*2] |-> cts_n_q && !enter_cmd;
  endproperty
  a_spi: assert property (p_spi) else $error("active off uart");
endmodule : smc_ctrl

// ==== tb/smc_host.sv ====
`timescale 1ns/1ps
module smc_host (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cts_n,
  input wire logic slow,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  output logic ser_tx_ready,
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data
);
  logic [7:0] rxq[$];
  initial begin
    ser_rx_valid = 1'b0;
    ser_rx_data = 8'h00;
  end
  // slow host is ready for reply bytes in every other cycle only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_tx_ready <= 1'b0;
    end else begin
      ser_tx_ready <= slow ? ~ser_tx_ready : 1'b1;
    end
  end
  always @(posedge core_clk) begin
    if (ser_tx_valid && ser_tx_ready) begin
      rxq.push_back(ser_tx_data);
    end
  end
  // one character; frc ignores clear-to-send on purpose
  task automatic send(input logic [7:0] b, input bit frc);
    int n;
    n = 0;
    while (!frc && cts_n !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    ser_rx_valid <= 1'b1;
    ser_rx_data <= b;
    @(posedge core_clk);
    ser_rx_valid <= 1'b0;
    ser_rx_data <= ~b; // released line shows no stale byte
  endtask : send
endmodule : smc_host

// ==== tb/serial_mode_command_controller_test.sv ====
`timescale 1ns/1ps
module serial_mode_command_controller_test import smc_pkg::*; ;
  localparam int TK = 4;
  logic core_clk, reset_n, por_n, uart_sel, slow, rf_busy;
  logic ser_rx_valid, cts_n, ser_tx_valid, ser_tx_ready;
  logic [7:0] ser_rx_data, ser_tx_data, rf_rx_data, rf_tx_data, reg_addr;
  logic rf_rx_valid, rf_rx_ready, rf_tx_valid, rf_tx_last, rf_tx_ready;
  logic reg_wr, reg_rd;
  logic [15:0] rf_dest;
  logic [2:0] baud_sel;
  logic [1:0] trx_state, op_mode;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [7:0] txq[$], sq[$];
  int fail_count, checks_done, pkts, cyc, seed, n;
  bit saw_tx, saw_stop;
  smc_ctrl #(.TICK_CYC(TK)) dut (.core_clk, .reset_n, .por_n, .uart_sel,
    .ser_rx_valid, .ser_rx_data, .cts_n, .ser_tx_valid, .ser_tx_data,
    .ser_tx_ready, .rf_busy, .rf_rx_valid, .rf_rx_data, .rf_rx_ready,
    .rf_tx_valid, .rf_tx_data, .rf_tx_last, .rf_tx_ready, .rf_dest,
    .baud_sel, .trx_state, .op_mode, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  smc_host host (.core_clk, .reset_n, .cts_n, .slow, .ser_tx_valid,
    .ser_tx_data, .ser_tx_ready, .ser_rx_valid, .ser_rx_data);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // radio side accepts at random; also the hang limit
  always @(posedge core_clk) begin
    rf_tx_ready <= 1'($random(seed));
    cyc <= cyc + 1;
    if (rf_tx_valid && rf_tx_ready) begin
      txq.push_back(rf_tx_data);
      pkts = pkts + int'(rf_tx_last);
    end
    if (trx_state === 2'h2) saw_tx = 1'b1;
    if (cts_n === 1'b1) saw_stop = 1'b1;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // expected read reply: four hex digits, then a return
  function automatic string hexrep(input logic [15:0] v);
    hexrep = {$sformatf("%04h", v), "\r"};
  endfunction : hexrep
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  task automatic setp(input int idx, input logic [15:0] v);
    wr(REG_PAR0 + 8'(4 * idx), 32'(v));
    wr(REG_CTRL, 32'h1 << CTRL_APPLY_BIT);
  endtask : setp
  task automatic hs(input string s);
    foreach (s[k]) begin
      host.send(s[k], 1'b0);
      sq.push_back(s[k]);
    end
  endtask : hs
  task automatic hrand(input int cnt, input bit frc);
    logic [7:0] b;
    repeat (cnt) begin
      b = 8'($random(seed));
      if (b == 8'h2B) b = 8'h2A; // no accidental escape start
      host.send(b, frc);
      sq.push_back(b);
    end
  endtask : hrand
  task automatic expect_pkt(input int bound);
    n = 0;
    while (pkts == 0 && n < bound) begin
      @(posedge core_clk);
      n++;
    end
    @(negedge core_clk);
    chk(pkts, 1);
    chk(txq.size(), sq.size());
    foreach (sq[k]) chk(txq[k], sq[k]);
    txq.delete();
    sq.delete();
    pkts = 0;
  endtask : expect_pkt
  task automatic expect_rx(input string s);
    n = 0;
    while (host.rxq.size() < s.len() && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    @(negedge core_clk);
    foreach (s[k]) chk(host.rxq[k], s[k]);
    host.rxq.delete();
  endtask : expect_rx
  task automatic cmd(input string c, input string r);
    hs(c);
    expect_rx(r);
    sq.delete();
  endtask : cmd
  task automatic wait_mode(input logic [1:0] m, input int bound);
    n = 0;
    while (op_mode !== m && n < bound) begin
      @(posedge core_clk);
      n++;
    end
    chk(op_mode, m);
  endtask : wait_mode
  // silence, escape string, then silence kept by not sending
  task automatic esc();
    repeat (10 * TK) @(posedge core_clk);
    for (int k = 0; k < 3; k++) host.send(8'h2B, 1'b0);
  endtask : esc
  task automatic rfs(input logic [7:0] b);
    n = 0;
    @(posedge core_clk);
    rf_rx_valid <= 1'b1;
    rf_rx_data <= b;
    do begin
      @(posedge core_clk);
      n++;
    end while (rf_rx_ready !== 1'b1 && n < 500);
    rf_rx_valid <= 1'b0;
    rf_rx_data <= ~b;
  endtask : rfs
  initial begin
    seed = 22407;
    {reset_n, por_n, uart_sel, slow, rf_busy} = 5'b00100;
    {rf_rx_valid, rf_rx_data, reg_wr, reg_rd} = 11'h000;
    {reg_addr, reg_wdata} = 40'h0;
    repeat (8) @(posedge core_clk);
    chk(baud_sel, 3);
    chk(op_mode, MODE_DATA);
    {reset_n, por_n} <= 2'b11;
    repeat (2) @(posedge core_clk);
    rd(REG_PAR0 + 8'(4 * P_BAUD));
    chk(d, 32'h3);
    rd(8'hF0);
    chk(d, 32'h0);
    wr(REG_PAR0 + 8'(4 * P_GUARD), 32'h5);
    rd(REG_PAR0 + 8'(4 * P_GUARD));
    chk(d, 32'(PAR_DEF[P_GUARD]));
    setp(P_CMD_TO, 16'h001E);
    setp(P_PKT_TO, 16'h0002);
    rd(REG_PAR0 + 8'(4 * P_GUARD));
    chk(d, 32'h5);
    hrand(1 + $unsigned($random(seed)) % 8, 1'b0);
    expect_pkt(400);
    chk(saw_tx, 1'b1);
    // radio busy: data must wait for the next trigger
    @(posedge core_clk) rf_busy <= 1'b1;
    hrand(4, 1'b0);
    repeat (100) @(posedge core_clk);
    chk(pkts, 0);
    chk(trx_state, TRX_RX);
    rf_busy <= 1'b0;
    expect_pkt(400);
    repeat (10) @(posedge core_clk);
    chk(trx_state, TRX_IDLE);
    repeat (10 * TK) @(posedge core_clk);
    hs("++x");
    expect_pkt(400);
    chk(op_mode, MODE_DATA);
    setp(P_PKT_TO, 16'h0000);
    hrand(1, 1'b0);
    expect_pkt(20);
    // size limit with the idle trigger out of reach
    setp(P_PKT_TO, 16'h0FFF);
    saw_stop = 1'b0;
    hrand(100, 1'b1);
    chk(saw_stop, 1'b1);
    expect_pkt(1000);
    hs("ab");
    esc();
    expect_pkt(400);
    wait_mode(MODE_CMD, 400);
    expect_rx("OK\r");
    rd(REG_STATUS);
    chk(d, 32'(MODE_CMD) << ST_MODE_LSB);
    slow <= 1'b1;
    cmd("ATGT\r", hexrep(16'h0005));
    cmd("ATBD5\r", "OK\r");
    cmd("ATDL1F\r", "OK\r");
    chk(baud_sel, 3);
    cmd("ATQQ\r", "ERROR\r");
    cmd("ATAC\r", "OK\r");
    chk(baud_sel, 5);
    chk(rf_dest, 16'h001F);
    cmd("ATWR\r", "OK\r");
    cmd("ATBD6\r", "OK\r");
    hs("ATCN\r");
    wait_mode(MODE_DATA, 100);
    chk(baud_sel, 6);
    repeat (50) @(posedge core_clk);
    host.rxq.delete();
    sq.delete();
    esc();
    wait_mode(MODE_CMD, 400);
    expect_rx("OK\r");
    repeat (40) @(posedge core_clk);
    chk(op_mode, MODE_CMD);
    wait_mode(MODE_DATA, 300);
    // plain reset keeps only what was stored
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(baud_sel, 5);
    setp(P_PKT_TO, 16'h0000);
    uart_sel <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(cts_n, 1'b1);
    hrand(2, 1'b1);
    repeat (50) @(posedge core_clk);
    chk(pkts, 0);
    sq.delete();
    uart_sel <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      sq.push_back(8'($random(seed)));
      rfs(sq[k]);
    end
    repeat (50) @(posedge core_clk);
    foreach (sq[k]) chk(host.rxq[k], sq[k]);
    print_verdict();
  end
endmodule : serial_mode_command_controller_test
